// ---- design/sbc_pkg.sv ----
// shared constants and types of the supervisory block
package sbc_pkg;
   typedef enum logic [2:0] {
      ST_RESET, ST_NREQ, ST_NORMAL, ST_STOP, ST_SLEEP
   } sbc_state_e;

   // operating select codes written with each mode control write
   localparam logic [1:0] OP_SLEEP = 2'h1;
   localparam logic [1:0] OP_STOP  = 2'h2;

   // watchdog config pin sense result
   localparam logic [1:0] CFG_RES  = 2'h0;
   localparam logic [1:0] CFG_GND  = 2'h1;

   localparam logic [1:0] FLAGS_ALL = 2'h3;
   localparam int unsigned SRC_WKIN = 0;
   localparam int unsigned SRC_LIN = 1;
   localparam int unsigned SRC_TMR = 2;
   localparam int unsigned SW_ONE  = 0;
   localparam int unsigned SW_TWO  = 1;
   localparam int unsigned PF_ONE  = 2;
   localparam int unsigned PF_TWO  = 3;

   localparam int unsigned CLK_MHZ = 250;
   // times as specified, in their own unit
   localparam int unsigned NREQ_TIMEOUT_MS  = 150;
   localparam int unsigned WD_INT_TB_MS     = 150;
   localparam int unsigned WD_RES_TB_MS     = 100;
   localparam int unsigned RST_EXTEND_US    = 1000;
   localparam int unsigned CYC_BASE_MS      = 10;
   localparam int unsigned CYC_ON_US        = 100;
   localparam int unsigned BUS_WAKE_FILT_NS = 2000;
   localparam int unsigned RST_GLITCH_NS    = 1000;

   // derived cycle counts; minimum times round up
   localparam int unsigned NREQ_CYC = NREQ_TIMEOUT_MS * CLK_MHZ * 1000;
   localparam int unsigned WD_INT_CYC = WD_INT_TB_MS * CLK_MHZ * 1000;
   localparam int unsigned WD_RES_CYC = WD_RES_TB_MS * CLK_MHZ * 1000;
   localparam int unsigned RST_EXT_CYC = RST_EXTEND_US * CLK_MHZ;
   localparam int unsigned CYC_BASE_CYC = CYC_BASE_MS * CLK_MHZ * 1000;
   localparam int unsigned CYC_ON_CYC = CYC_ON_US * CLK_MHZ;
   localparam int unsigned LIN_FILT_CYC =
      (BUS_WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RST_FILT_CYC =
      (RST_GLITCH_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- design/sbc_filt_if.sv ----
// carrier between the main block and a pulse-length filter
`timescale 1ns/1ps
interface sbc_filt_if;
   logic raw;
   logic held;
   modport src (output raw, input held);
   modport flt (input raw, output held);
endinterface // sbc_filt_if

// ---- design/sbc_filt.sv ----
// level held for LEN cycles detector
`timescale 1ns/1ps
module sbc_filt #(
   parameter int unsigned LEN = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // filtered signal
   sbc_filt_if.flt  f
);
   localparam int unsigned W = $clog2(LEN + 1);
   logic [W-1:0] cnt_r;

   // saturating count; any gap restarts the filter
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_r <= '0;
      end else if (!f.raw) begin
         cnt_r <= '0;
      end else if (cnt_r != W'(LEN)) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign f.held = (cnt_r == W'(LEN));
endmodule // sbc_filt

// ---- design/sbc_ctrl.sv ----
// wake-up, reset pin, window watchdog and high side switch control
`timescale 1ns/1ps
module sbc_ctrl #(
   parameter int unsigned NREQ_CYCLES = sbc_pkg::NREQ_CYC,
   parameter int unsigned WD_INT_CYCLES = sbc_pkg::WD_INT_CYC,
   parameter int unsigned WD_RES_CYCLES = sbc_pkg::WD_RES_CYC,
   parameter int unsigned RST_EXT_CYCLES = sbc_pkg::RST_EXT_CYC,
   parameter int unsigned CYC_BASE_CYCLES = sbc_pkg::CYC_BASE_CYC,
   parameter int unsigned CYC_ON_CYCLES = sbc_pkg::CYC_ON_CYC
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   // mode control
   input  wire logic       op_write_in,
   input  wire logic [1:0] op_select_in,
   input  wire logic       overvoltage_shutdown_enable_in,
   input  wire logic [1:0] wd_prescale_in,
   // wake control
   input  wire logic       wake_input_in,
   input  wire logic       wake_input_enable_in,
   input  wire logic       wake_mux_select_in,
   input  wire logic       timer_function_select_in,
   input  wire logic [2:0] cyclic_period_select_in,
   // switch control and sense
   input  wire logic       switch_write_in,
   input  wire logic       switch_one_on_in,
   input  wire logic       switch_two_on_in,
   input  wire logic       pulse_follow_one_in,
   input  wire logic       pulse_follow_two_in,
   input  wire logic       pulse_input_pin_in,
   input  wire logic [1:0] open_load_in,
   input  wire logic [1:0] current_limit_in,
   input  wire logic       over_temp_in,
   input  wire logic       overvoltage_in,
   input  wire logic       switch_irq_mask_in,
   // pins
   input  wire logic [1:0] watchdog_config_pin_in,
   input  wire logic       chip_select_n_in,
   input  wire logic       lin_rx_in,
   input  wire logic       reset_pin_in,
   output logic            reset_pin_out,
   output logic            reset_pin_oe_n_out,
   // interrupt
   input  wire logic       irq_ack_in,
   output logic            irq_n_out,
   // status
   output sbc_pkg::sbc_state_e mode_out,
   output logic            regulator_on_out,
   output logic            wake_status_out,
   output logic [2:0]      wake_src_out,
   output logic            hs_event_out,
   output logic            switch_one_out,
   output logic            switch_two_out,
   output logic [1:0]      open_load_flag_out,
   output logic [1:0]      current_limit_flag_out,
   output logic            watchdog_disabled_flag_out,
   output logic            watchdog_fault_out
);
   import sbc_pkg::*;

   sbc_state_e  state_r, state_nxt;
   logic [31:0] tmr_r;
   logic        ext_r, ext_nxt;
   logic [1:0]  cfg_r;
   logic [3:0]  sw_r;
   logic        wk_arm_r, wk_ref_r, cs_q_r, ot_q_r;
   logic        hs_ot_r, hs_dis_r, irq_pend_r;
   logic        lp, wd_on, cyc_mode, per_end, cs_win, cs_rise;
   logic        wk_wake, cyc_wake, frc_wake, lin_wake, any_wake;
   logic        ext_low, early_svc, wd_ovf, shut;
   logic [31:0] wd_per, lp_per;

   sbc_filt_if rst_f ();
   sbc_filt_if lin_f ();

   // own drive masked so the pin is never seen as external reset
   assign rst_f.raw = !reset_pin_in && reset_pin_oe_n_out;
   assign lin_f.raw = !lin_rx_in;

   sbc_filt #(.LEN(RST_FILT_CYC)) u_rst_filt (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .f          (rst_f)
   );
   sbc_filt #(.LEN(LIN_FILT_CYC)) u_lin_filt (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .f          (lin_f)
   );

   assign lp = (state_r == ST_STOP) || (state_r == ST_SLEEP);
   assign ext_low = rst_f.held;
   assign wd_on = (cfg_r != CFG_GND);
   assign wd_per = ((cfg_r == CFG_RES) ? WD_RES_CYCLES : WD_INT_CYCLES)
      << wd_prescale_in;
   assign early_svc = wd_on && op_write_in && (tmr_r < (wd_per >> 1));
   assign wd_ovf = wd_on && (tmr_r == wd_per - 32'h1);
   // timer with a switch armed is cyclic sense, without is forced
   assign cyc_mode = timer_function_select_in
      && (sw_r[SW_ONE] || sw_r[SW_TWO]);
   assign lp_per = CYC_BASE_CYCLES << cyclic_period_select_in;
   assign per_end = lp && timer_function_select_in
      && (tmr_r == lp_per - 32'h1);
   assign cs_win = lp && cyc_mode
      && (tmr_r >= lp_per - CYC_ON_CYCLES);
   assign cyc_wake = per_end && cyc_mode && wk_arm_r
      && (wake_input_in != wk_ref_r);
   assign frc_wake = per_end && !cyc_mode;
   assign wk_wake = lp && wk_arm_r && !cyc_mode
      && (wake_input_in != wk_ref_r);
   // filter still reports long dominant in the release cycle
   assign lin_wake = lp && lin_f.held && lin_rx_in;
   assign cs_rise = chip_select_n_in && !cs_q_r;
   assign any_wake = wk_wake || cyc_wake || frc_wake || lin_wake;
   assign shut = over_temp_in
      || (overvoltage_in && overvoltage_shutdown_enable_in);

   always_comb begin
      state_nxt = state_r;
      ext_nxt = ext_r;
      if (ext_low) begin
         state_nxt = ST_RESET;
         ext_nxt = 1'b0;
      end else begin
         case (state_r)
            ST_RESET: begin
               if (!ext_r || tmr_r >= RST_EXT_CYCLES) begin
                  state_nxt = wd_on ? ST_NREQ : ST_NORMAL;
               end
            end
            ST_NREQ: begin
               if (op_write_in) begin
                  state_nxt = ST_NORMAL;
               end else if (tmr_r == NREQ_CYCLES - 32'h1) begin
                  state_nxt = ST_RESET;
                  ext_nxt = 1'b1;
               end
            end
            ST_NORMAL: begin
               if (early_svc || wd_ovf) begin
                  state_nxt = ST_RESET;
                  ext_nxt = 1'b1;
               end else if (op_write_in && op_select_in == OP_SLEEP) begin
                  state_nxt = ST_SLEEP;
               end else if (op_write_in && op_select_in == OP_STOP) begin
                  state_nxt = ST_STOP;
               end
            end
            ST_STOP: begin
               if (any_wake || cs_rise) begin
                  state_nxt = ST_NREQ;
               end
            end
            ST_SLEEP: begin
               if (any_wake) begin
                  state_nxt = ST_RESET;
                  ext_nxt = 1'b1;
               end
            end
            default: begin
               state_nxt = ST_RESET;
               ext_nxt = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= ST_RESET;
         ext_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         ext_r <= ext_nxt;
      end
   end

   // one timer serves reset stretch, timeouts, watchdog and cycles
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tmr_r <= '0;
      end else if (state_nxt != state_r || op_write_in || per_end) begin
         tmr_r <= '0;
      end else begin
         tmr_r <= tmr_r + 32'h1;
      end
   end

   // config pin only trusted while the controller is held in reset
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_r <= CFG_RES;
      end else if (state_r == ST_RESET) begin
         cfg_r <= watchdog_config_pin_in;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wk_arm_r <= 1'b0;
         wk_ref_r <= 1'b0;
      end else if (!lp && (state_nxt == ST_STOP
                           || state_nxt == ST_SLEEP)) begin
         wk_arm_r <= wake_input_enable_in && !wake_mux_select_in;
         wk_ref_r <= wake_input_in;
      end else if (per_end) begin
         wk_ref_r <= wake_input_in;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cs_q_r <= 1'b1;
         ot_q_r <= 1'b0;
         wake_status_out <= 1'b0;
      end else begin
         cs_q_r <= chip_select_n_in;
         ot_q_r <= over_temp_in;
         wake_status_out <= wake_input_in;
      end
   end

   // source flags survive reset mode so a sleep wake is still reported
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wake_src_out <= '0;
      end else begin
         wake_src_out <= (irq_ack_in ? 3'h0 : wake_src_out)
            | {3{lp}} & {frc_wake, lin_wake, wk_wake || cyc_wake};
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sw_r <= '0;
      end else if (state_r == ST_RESET) begin
         sw_r <= '0;
      end else if (switch_write_in) begin
         sw_r <= {pulse_follow_two_in, pulse_follow_one_in,
                  switch_two_on_in, switch_one_on_in};
      end
   end

   // shutdown holds until a switch write after the fault has gone
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hs_dis_r <= 1'b0;
         hs_ot_r <= 1'b0;
      end else begin
         hs_dis_r <= shut || (hs_dis_r && !switch_write_in);
         hs_ot_r <= over_temp_in
            || (hs_ot_r && !switch_write_in);
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         switch_one_out <= 1'b0;
         switch_two_out <= 1'b0;
      end else if (shut || hs_dis_r) begin
         switch_one_out <= 1'b0;
         switch_two_out <= 1'b0;
      end else if (state_r == ST_NREQ || state_r == ST_NORMAL) begin
         switch_one_out <= sw_r[SW_ONE]
            && (!sw_r[PF_ONE] || pulse_input_pin_in);
         switch_two_out <= sw_r[SW_TWO]
            && (!sw_r[PF_TWO] || pulse_input_pin_in);
      end else begin
         switch_one_out <= cs_win && sw_r[SW_ONE];
         switch_two_out <= cs_win && sw_r[SW_TWO];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         open_load_flag_out <= '0;
         current_limit_flag_out <= '0;
      end else if (over_temp_in || hs_ot_r) begin
         open_load_flag_out <= FLAGS_ALL;
         current_limit_flag_out <= FLAGS_ALL;
      end else begin
         open_load_flag_out <= open_load_in;
         current_limit_flag_out <= current_limit_in;
      end
   end

   // irq only in normal request, normal and stop; set beats clear
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hs_event_out <= 1'b0;
         irq_pend_r <= 1'b0;
      end else begin
         hs_event_out <= (over_temp_in && !ot_q_r)
            || (hs_event_out && !irq_ack_in);
         if (state_r == ST_RESET || state_r == ST_SLEEP) begin
            irq_pend_r <= 1'b0;
         end else begin
            irq_pend_r <= (state_r == ST_STOP && any_wake)
               || (over_temp_in && !ot_q_r && switch_irq_mask_in)
               || (irq_pend_r && !irq_ack_in);
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_n_out <= 1'b1;
         mode_out <= ST_RESET;
         regulator_on_out <= 1'b1;
         reset_pin_out <= 1'b0;
         reset_pin_oe_n_out <= 1'b0;
         watchdog_disabled_flag_out <= 1'b0;
         watchdog_fault_out <= 1'b0;
      end else begin
         irq_n_out <= !irq_pend_r;
         mode_out <= state_r;
         regulator_on_out <= (state_r != ST_SLEEP);
         reset_pin_out <= 1'b0;
         // pin driven for internal resets only, not for the pin's own
         reset_pin_oe_n_out <= !(state_nxt == ST_RESET
                                 && ext_nxt);
         watchdog_disabled_flag_out <= (cfg_r == CFG_GND);
         watchdog_fault_out <= (cfg_r != CFG_GND)
            && (cfg_r != CFG_RES);
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_sleep_wake;
      state_r == ST_SLEEP && any_wake && !ext_low;
   endsequence
   property p_sleep_reset;
      s_sleep_wake |=> state_r == ST_RESET ##1 !reset_pin_oe_n_out;
   endproperty
   a_sleep_reset: assert property (p_sleep_reset)
      else $error("sleep wake did not go through reset");

   property p_ext_hold;
      ext_low |=> state_r == ST_RESET;
   endproperty
   a_ext_hold: assert property (p_ext_hold)
      else $error("reset pin low without reset state");

   property p_stop_irq;
      state_r == ST_STOP && any_wake && !ext_low |=> ##1 !irq_n_out;
   endproperty
   a_stop_irq: assert property (p_stop_irq)
      else $error("stop wake raised no interrupt");

   property p_no_wkin;
      !lp && (state_nxt == ST_STOP || state_nxt == ST_SLEEP)
         && wake_mux_select_in |=> !wk_arm_r && !wk_wake;
   endproperty
   a_no_wkin: assert property (p_no_wkin)
      else $error("muxed wake input stayed armed");

   property p_cs_wake;
      state_r == ST_STOP && cs_rise && !any_wake && !ext_low
         |=> state_r == ST_NREQ && !irq_pend_r;
   endproperty
   a_cs_wake: assert property (p_cs_wake)
      else $error("chip select wake wrong");

   property p_early;
      state_r == ST_NORMAL && early_svc && !ext_low
         |=> state_r == ST_RESET ##1 !reset_pin_oe_n_out;
   endproperty
   a_early: assert property (p_early)
      else $error("early service not punished");

   property p_wd_off;
      state_r == ST_RESET && watchdog_config_pin_in == CFG_GND
         && !ext_low ##1 state_r != ST_RESET |-> state_r == ST_NORMAL;
   endproperty
   a_wd_off: assert property (p_wd_off)
      else $error("grounded config did not skip normal request");

   property p_pwm;
      (state_r == ST_NREQ || state_r == ST_NORMAL) && sw_r[SW_ONE]
         && sw_r[PF_ONE] && !shut && !hs_dis_r
         |=> switch_one_out == $past(pulse_input_pin_in);
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("switch one does not follow pulse input");

   property p_ot;
      over_temp_in |=> !switch_one_out && !switch_two_out
         && open_load_flag_out == FLAGS_ALL
         && current_limit_flag_out == FLAGS_ALL;
   endproperty
   a_ot: assert property (p_ot)
      else $error("over-temperature not handled");

   property p_irq_hold;
      irq_pend_r && !irq_ack_in && state_r != ST_RESET
         && state_r != ST_SLEEP |=> irq_pend_r ##1 !irq_n_out;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq released without acknowledge");
endmodule // sbc_ctrl

// ---- bench/sbc_mcu.sv ----
// controller stand-in that answers interrupts with a status read
`timescale 1ns/1ps
module sbc_mcu (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   // interrupt and read
   input  wire logic       irq_n_in,
   input  wire logic [3:0] ack_delay_in,
   output logic            irq_ack_out
);
   logic [3:0] wait_r;
   // read latency is chosen by the bench, so irq must hold meanwhile
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_r      <= 4'h0;
         irq_ack_out <= 1'b0;
      end else begin
         irq_ack_out <= 1'b0;
         if (irq_n_in || irq_ack_out) begin
            wait_r <= 4'h0;
         end else if (wait_r == ack_delay_in) begin
            irq_ack_out <= 1'b1;
         end else begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule // sbc_mcu

// ---- bench/tb.sv ----
// self-checking bench for the supervisory block
`timescale 1ns/1ps
module tb;
   import sbc_pkg::*;
   localparam int NREQ = 300;
   localparam int WD   = 200;
   localparam int WDI  = 400;
   localparam int EXT  = 20;
   localparam int CYC  = 64;
   logic       clk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic       op_write_in, overvoltage_shutdown_enable_in, wake_input_in;
   logic       wake_input_enable_in, wake_mux_select_in;
   logic       timer_function_select_in, switch_write_in, switch_one_on_in;
   logic       switch_two_on_in, pulse_follow_one_in, pulse_follow_two_in;
   logic       pulse_input_pin_in, over_temp_in, overvoltage_in;
   logic       switch_irq_mask_in, chip_select_n_in, lin_rx_in, irq_ack_in;
   logic       ext_rst_n, reset_pin_out, reset_pin_oe_n_out, irq_n_out;
   logic       regulator_on_out, wake_status_out, hs_event_out;
   logic       switch_one_out, switch_two_out, watchdog_disabled_flag_out;
   logic       watchdog_fault_out;
   logic [1:0] op_select_in, wd_prescale_in, open_load_in, current_limit_in;
   logic [1:0] watchdog_config_pin_in, open_load_flag_out;
   logic [1:0] current_limit_flag_out;
   logic [2:0] cyclic_period_select_in, wake_src_out;
   logic [3:0] ack_delay;
   wire        reset_pin_in;
   sbc_state_e mode_out;
   int         fails = 0;
   int         n_tests = 0;

   // pin is open drain with pull-up: either side may pull it low
   assign reset_pin_in = ext_rst_n & (reset_pin_oe_n_out | reset_pin_out);

   sbc_ctrl #(.NREQ_CYCLES(NREQ), .WD_INT_CYCLES(WDI), .WD_RES_CYCLES(WD),
      .RST_EXT_CYCLES(EXT), .CYC_BASE_CYCLES(CYC), .CYC_ON_CYCLES(8))
   sbc_ctrl_inst (.clk_in, .reset_n_in, .op_write_in, .op_select_in,
      .overvoltage_shutdown_enable_in, .wd_prescale_in, .wake_input_in,
      .wake_input_enable_in, .wake_mux_select_in, .timer_function_select_in,
      .cyclic_period_select_in, .switch_write_in, .switch_one_on_in,
      .switch_two_on_in, .pulse_follow_one_in, .pulse_follow_two_in,
      .pulse_input_pin_in, .open_load_in, .current_limit_in, .over_temp_in,
      .overvoltage_in, .switch_irq_mask_in, .watchdog_config_pin_in,
      .chip_select_n_in, .lin_rx_in, .reset_pin_in, .reset_pin_out,
      .reset_pin_oe_n_out, .irq_ack_in, .irq_n_out, .mode_out,
      .regulator_on_out, .wake_status_out, .wake_src_out, .hs_event_out,
      .switch_one_out, .switch_two_out, .open_load_flag_out,
      .current_limit_flag_out, .watchdog_disabled_flag_out,
      .watchdog_fault_out);

   sbc_mcu sbc_mcu_inst (.clk_in, .reset_n_in, .irq_n_in(irq_n_out),
      .ack_delay_in(ack_delay), .irq_ack_out(irq_ack_in));

   always #2 clk_in = ~clk_in;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({7'h0, g}, {7'h0, e});
   endtask
   task automatic cm(input sbc_state_e m);
      chk(8'(mode_out), 8'(m));
   endtask
   task automatic wm(input sbc_state_e m, input int lim);
      for (int i = 0; i < lim && mode_out !== m; i++) tick(1);
      cm(m);
   endtask
   task automatic op(input logic [1:0] s);
      @(posedge clk_in);
      op_write_in  <= 1'b1;
      op_select_in <= s;
      @(posedge clk_in);
      op_write_in <= 1'b0;
      tick(2);
   endtask
   task automatic sw(input logic [3:0] b);
      @(posedge clk_in);
      switch_write_in <= 1'b1;
      {pulse_follow_two_in, pulse_follow_one_in, switch_two_on_in,
       switch_one_on_in} <= b;
      @(posedge clk_in);
      switch_write_in <= 1'b0;
      tick(2);
   endtask
   task automatic rst(input logic [1:0] c);
      reset_n_in             <= 1'b0;
      watchdog_config_pin_in <= c;
      tick(2);
      reset_n_in <= 1'b1;
      tick(1);
      cm(ST_RESET);
      chk1(reset_pin_oe_n_out, 1'b0);
   endtask
   // service only once the closed half of the window has passed
   task automatic to_norm();
      wm(ST_NREQ, 2 * EXT);
      op(2'h0);
      tick(WD / 2 + 5);
   endtask
   task automatic to_stop();
      to_norm();
      op(OP_STOP);
      cm(ST_STOP);
   endtask
   task automatic done(input string s);
      $display("test %0s done", s);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      tick(20000);
      fails++;
      final_report();
   end

   initial begin
      int i;
      {op_write_in, overvoltage_shutdown_enable_in, wake_input_in,
       wake_input_enable_in, wake_mux_select_in, timer_function_select_in,
       switch_write_in, switch_one_on_in, switch_two_on_in,
       pulse_follow_one_in, pulse_follow_two_in, pulse_input_pin_in,
       over_temp_in, overvoltage_in, switch_irq_mask_in} = '0;
      {op_select_in, wd_prescale_in, open_load_in, current_limit_in,
       cyclic_period_select_in} = '0;
      {chip_select_n_in, lin_rx_in, ext_rst_n} = 3'h7;
      watchdog_config_pin_in = CFG_RES;
      ack_delay = 4'hf;
      rst(CFG_RES);
      wm(ST_NREQ, 2 * EXT);
      chk1(watchdog_disabled_flag_out, 1'b0);
      chk1(watchdog_fault_out, 1'b0);
      tick(NREQ - 20);
      cm(ST_NREQ);
      wm(ST_RESET, 30);
      done("nreq_timeout");
      wm(ST_NREQ, 2 * EXT);
      sw(4'h7);
      pulse_input_pin_in <= 1'b1;
      tick(3);
      chk({6'h0, switch_two_out, switch_one_out}, 8'h3);
      pulse_input_pin_in <= 1'b0;
      open_load_in       <= 2'h2;
      current_limit_in   <= 2'h1;
      tick(3);
      chk({6'h0, switch_two_out, switch_one_out}, 8'h2);
      chk({4'h0, open_load_flag_out, current_limit_flag_out}, 8'h9);
      {open_load_in, current_limit_in} <= 4'h0;
      switch_irq_mask_in <= 1'b1;
      over_temp_in       <= 1'b1;
      tick(4);
      chk({4'h0, open_load_flag_out, current_limit_flag_out}, 8'hf);
      chk({5'h0, switch_two_out, hs_event_out, irq_n_out}, 8'h2);
      over_temp_in <= 1'b0;
      tick(3);
      chk1(switch_two_out, 1'b0);
      sw(4'h2);
      chk1(switch_two_out, 1'b1);
      overvoltage_shutdown_enable_in <= 1'b1;
      overvoltage_in                 <= 1'b1;
      tick(3);
      chk1(switch_two_out, 1'b0);
      overvoltage_in <= 1'b0;
      sw(4'h2);
      chk1(switch_two_out, 1'b1);
      sw(4'h0);
      done("switches");
      op(2'h0);
      cm(ST_NORMAL);
      tick(10);
      op(2'h0);
      cm(ST_RESET);
      to_norm();
      op(2'h0);
      cm(ST_NORMAL);
      tick(WD - 30);
      cm(ST_NORMAL);
      wm(ST_RESET, 40);
      done("watchdog");
      wake_input_enable_in <= 1'b1;
      to_stop();
      chk1(regulator_on_out, 1'b1);
      wake_input_in <= 1'b1;
      wm(ST_NREQ, 10);
      tick(2);
      chk({4'h0, wake_src_out, wake_status_out}, 8'h3);
      chk1(irq_n_out, 1'b0);
      tick(8);
      chk1(irq_n_out, 1'b0);
      tick(12);
      chk1(irq_n_out, 1'b1);
      done("stop_wake_input");
      ack_delay          <= 4'h2;
      wake_mux_select_in <= 1'b1;
      to_stop();
      wake_input_in <= 1'b0;
      tick(20);
      cm(ST_STOP);
      wake_mux_select_in <= 1'b0;
      lin_rx_in          <= 1'b0;
      tick(int'(LIN_FILT_CYC) - 50);
      lin_rx_in <= 1'b1;
      tick(20);
      cm(ST_STOP);
      lin_rx_in <= 1'b0;
      tick(int'(LIN_FILT_CYC) + 10);
      cm(ST_STOP);
      lin_rx_in <= 1'b1;
      wm(ST_NREQ, 10);
      chk(8'(wake_src_out), 8'h2);
      done("lin_wake");
      wake_input_enable_in <= 1'b0;
      to_stop();
      chip_select_n_in <= 1'b0;
      wake_input_in    <= 1'b1;
      tick(3);
      cm(ST_STOP);
      wake_input_in    <= 1'b0;
      chip_select_n_in <= 1'b1;
      wm(ST_NREQ, 10);
      tick(4);
      chk({4'h0, wake_src_out, irq_n_out}, 8'h1);
      wake_input_enable_in <= 1'b1;
      to_stop();
      ext_rst_n <= 1'b0;
      tick(int'(RST_FILT_CYC) + 5);
      cm(ST_RESET);
      tick(2 * EXT);
      cm(ST_RESET);
      chk1(reset_pin_oe_n_out, 1'b1);
      ext_rst_n <= 1'b1;
      wm(ST_NREQ, 8);
      chk1(irq_n_out, 1'b1);
      done("silent_wakes");
      timer_function_select_in <= 1'b1;
      cyclic_period_select_in  <= 3'h1;
      to_norm();
      op(OP_SLEEP);
      cm(ST_SLEEP);
      chk1(regulator_on_out, 1'b0);
      tick(2 * CYC - 20);
      cm(ST_SLEEP);
      wm(ST_RESET, 40);
      chk({4'h0, wake_src_out, irq_n_out}, 8'h9);
      wm(ST_NREQ, 2 * EXT + 5);
      cyclic_period_select_in <= 3'h0;
      sw(4'h1);
      to_stop();
      tick(CYC);
      cm(ST_STOP);
      for (i = 0; i < CYC && switch_one_out !== 1'b1; i++) tick(1);
      chk1(switch_one_out, 1'b1);
      wake_input_in <= 1'b1;
      wm(ST_NREQ, 2 * CYC + 10);
      done("timer_wakes");
      rst(CFG_GND);
      wm(ST_NORMAL, 2 * EXT);
      chk1(watchdog_disabled_flag_out, 1'b1);
      tick(WD + 50);
      cm(ST_NORMAL);
      rst(2'h2);
      wm(ST_NREQ, 2 * EXT);
      chk1(watchdog_fault_out, 1'b1);
      wd_prescale_in <= 2'h1;
      op(2'h0);
      tick(WDI + 20);
      cm(ST_NORMAL);
      wm(ST_RESET, 2 * WDI);
      done("config_pin");
      final_report();
   end
endmodule // tb
